/* File: sim/somx_host_rx.sv */
`timescale 1ns/1ns
// ==========================================================
// host line receivers and quadrature counter
module somx_host_rx (
  input wire logic   aclk,
  input wire logic   aresetn,
  input wire logic   a,
  input wire logic   a_n,
  input wire logic   b,
  input wire logic   b_n,
  input wire logic   c3,
  input wire logic   c3_n,
  output logic [31:0] count_q,
  output logic [2:0] cmp_q
);
  logic [1:0] prev_q;
  wire [2:0] ok    = {c3 ^ c3_n, b ^ b_n, a ^ a_n};
  wire [2:0] rcv   = (ok & {c3, b, a}) | (~ok & ~cmp_q);
  wire [1:0] i_now = {cmp_q[0], cmp_q[0] ^ cmp_q[1]};
  wire [1:0] i_old = {prev_q[0], prev_q[0] ^ prev_q[1]};
  wire [1:0] dlt   = i_now - i_old;
  // x4 count, b leading a counts up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_q <= '0;
      prev_q <= '0;
      count_q <= '0;
    end else begin
      cmp_q <= rcv;
      prev_q <= cmp_q[1:0];
      if (dlt == 2'h1) count_q <= count_q + 32'h1;
      if (dlt == 2'h3) count_q <= count_q - 32'h1;
    end
  end
endmodule

/* File: sim/somx_output_mux_sva.sv */
`timescale 1ns/1ns
// ==========================================================
// output mux checker
module somx_output_mux_chk #(
  parameter int NOUT = 3
) (
  input wire logic            aclk,
  input wire logic            aresetn,
  input wire logic [NOUT-1:0] output_pin_q,
  input wire logic            phase_a_or_compare1_out,
  input wire logic            phase_a_or_compare1_out_n,
  input wire logic            phase_b_or_compare2_out,
  input wire logic            phase_b_or_compare2_out_n,
  input wire logic            compare3_out,
  input wire logic            compare3_out_n,
  input wire logic            output_function_error_1,
  input wire logic            output_function_error_2,
  input wire logic            irq_q,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [31:0]     s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire qa = phase_a_or_compare1_out;
  wire qb = phase_b_or_compare2_out;

  property p_rst_off;
    disable iff (1'b0) !aresetn |=> output_pin_q == '0 && !irq_q
      && !output_function_error_1 && !output_function_error_2;
  endproperty
  a_rst_off: assert property (p_rst_off)
    else $error("outputs active in reset");
  property p_pair_a;
    phase_a_or_compare1_out_n == !qa;
  endproperty
  a_pair_a: assert property (p_pair_a)
    else $error("pair a not complementary");
  property p_pair_b;
    phase_b_or_compare2_out_n == !qb;
  endproperty
  a_pair_b: assert property (p_pair_b)
    else $error("pair b not complementary");
  property p_pair_c3;
    compare3_out_n == !compare3_out;
  endproperty
  a_pair_c3: assert property (p_pair_c3)
    else $error("pair c3 not complementary");
  property p_gap;
    ($changed(qa) || $changed(qb)) |=> !($changed(qa) || $changed(qb)) [*6];
  endproperty
  a_gap: assert property (p_gap)
    else $error("pulse edges too close");
  property p_quad;
    !($changed(qa) && $changed(qb));
  endproperty
  a_quad: assert property (p_quad)
    else $error("a and b moved together");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped");
  c_pins: cover property (output_pin_q[0] && output_pin_q[1]);
  c_err2: cover property ($rose(output_function_error_2));
  c_irq: cover property ($rose(irq_q));
endmodule

bind somx_output_mux somx_output_mux_chk #(.NOUT(NOUT)) somx_output_mux_chk_inst (.*);

/* File: sim/tb_servo_output_function_mux.sv */
`timescale 1ns/1ns
`include "somx_cfg.svh"
module tb_servo_output_function_mux;
  logic        aclk = 1'b0, aresetn = 1'b0, scale_serial_line = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd, rx_count;
  logic [31:0] function_state = '0, divided_position = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid, s_axi_bvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_arready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, host_mode = '0;
  logic [2:0]  fra_kind = '0, compare_state = '0, output_pin_q, rx_cmp;
  logic        trial_run = 0, forced_stop_pos = 0, retracting = 0;
  logic        scale_phase_a_in = 0, scale_phase_b_in = 0, scale_phase_z_in = 0;
  logic        phase_a_or_compare1_out, phase_a_or_compare1_out_n;
  logic        phase_b_or_compare2_out, phase_b_or_compare2_out_n;
  logic        compare3_out, compare3_out_n, scale_ready_q, irq_q;
  logic        output_function_error_1, output_function_error_2;
  int          fails = 0, n_checks = 0;
  localparam logic [9:0] MT [11] = '{10'h000, 10'h101, 10'h202, 10'h220,
    10'h041, 10'h260, 10'h081, 10'h0a2, 10'h210, 10'h108, 10'h204};

  somx_output_mux somx_output_mux_inst (.*);
  somx_host_rx somx_host_rx_inst (.aclk(aclk), .aresetn(aresetn),
    .a(phase_a_or_compare1_out), .a_n(phase_a_or_compare1_out_n),
    .b(phase_b_or_compare2_out), .b_n(phase_b_or_compare2_out_n),
    .c3(compare3_out), .c3_n(compare3_out_n), .count_q(rx_count),
    .cmp_q(rx_cmp));

  always #20 aclk = ~aclk;

  // ========================================================
  // helpers
  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo;
    fails++;
    $display("[FAIL] %0t timeout", $time);
    finish_test();
  endtask
  task automatic settle;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    logic aw, w, bv;
    logic [1:0] br;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (bv) begin
        s_axi_bready <= 1'b0;
        chk(br, er);
        return;
      end
    end
    tmo();
  endtask
  task automatic rdr(input logic [11:0] a, input logic [1:0] er = 2'h0);
    logic ar, rv;
    logic [1:0] rr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) begin
        s_axi_rready <= 1'b0;
        chk(rr, er);
        return;
      end
    end
    tmo();
  endtask

  // ========================================================
  // scenarios
  task automatic t_reset;
    @(posedge aclk);
    function_state <= '1;
    settle();
    chk(output_pin_q, 3'h0);
    rdr(`SOMX_OFS_SEL0); chk(rd, `SOMX_SEL0_RST);
    rdr(`SOMX_OFS_SEL1); chk(rd, `SOMX_SEL1_RST);
    rdr(`SOMX_OFS_SEL2); chk(rd, `SOMX_SEL2_RST);
    rdr(`SOMX_OFS_WAIT); chk(rd, `SOMX_WAIT_RST);
    $display("t_reset done");
  endtask
  task automatic t_scale;
    localparam logic [7:0] QS = 8'h78;
    int n;
    chk(scale_ready_q, 1'b0);
    for (n = 0; n < 3000 && scale_ready_q !== 1'b1; n++) @(posedge aclk);
    if (n == 3000) tmo();
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      {scale_phase_a_in, scale_phase_b_in} <= QS[7 - 2 * (i % 4) -: 2];
      repeat (3) @(posedge aclk);
    end
    rdr(`SOMX_OFS_COUNT); chk(rd, 32'h8);
    rdr(`SOMX_OFS_IRQ_ST);
    chk(rd[2], 1'b1);
    wr(`SOMX_OFS_WAIT, 32'h10);
    chk(scale_ready_q, 1'b0);
    for (n = 0; n < 40 && scale_ready_q !== 1'b1; n++) @(posedge aclk);
    chk(scale_ready_q, 1'b1);
    $display("t_scale done");
  endtask
  task automatic t_map;
    wr(`SOMX_OFS_CTRL, 32'h1);
    wr(`SOMX_OFS_SEL0, 32'h0085_8585);
    wr(`SOMX_OFS_SEL1, 32'hff05_0505);
    rdr(`SOMX_OFS_SEL1); chk(rd, 32'h0005_0505);
    wr(`SOMX_OFS_SEL2, 32'h0);
    @(posedge aclk);
    function_state <= 32'h20;
    settle();
    chk(output_pin_q, 3'h3);
    @(posedge aclk);
    function_state <= ~32'h20;
    settle();
    chk(output_pin_q, 3'h0);
    $display("t_map done");
  endtask
  task automatic t_modes;
    wr(`SOMX_OFS_SEL0, 32'h0007_0605);
    for (int i = 0; i < 11; i++) begin
      @(posedge aclk);
      {host_mode, fra_kind, trial_run, forced_stop_pos, retracting} <= MT[i][9:2];
      function_state <= 32'h20 << MT[i][1:0];
      settle();
      chk(output_pin_q, {1'b0, MT[i][1:0] == 2'h0, 1'b1});
    end
    @(posedge aclk);
    {host_mode, fra_kind, trial_run, forced_stop_pos, retracting} <= '0;
    $display("t_modes done");
  endtask
  task automatic t_err;
    wr(`SOMX_OFS_IRQ_EN, 32'h1);
    wr(`SOMX_OFS_SEL0, 32'h0000_0303);
    settle();
    chk({irq_q, output_function_error_2, output_function_error_1}, 3'h5);
    wr(`SOMX_OFS_IRQ_EN, 32'h0);
    settle();
    chk(irq_q, 1'b0);
    wr(`SOMX_OFS_SEL0, 32'h0014_0000);
    settle();
    chk({irq_q, output_function_error_2, output_function_error_1}, 3'h2);
    rdr(`SOMX_OFS_IRQ_ST); chk(rd[1:0], 2'h3);
    wr(`SOMX_OFS_IRQ_EN, 32'h2);
    settle();
    chk(irq_q, 1'b1);
    wr(`SOMX_OFS_IRQ_CLR, 32'h3);
    settle();
    chk(irq_q, 1'b0);
    wr(`SOMX_OFS_SEL0, 32'h0083_0303);
    settle();
    chk({output_function_error_2, output_function_error_1}, 2'h0);
    wr(12'h0f0, 32'hffff_ffff, 2'h2);
    rdr(12'h0f0, 2'h2); chk(rd, 32'h0);
    $display("t_err done");
  endtask
  task automatic t_pulse;
    logic [2:0] cs;
    int n;
    @(posedge aclk);
    divided_position <= 32'hc;
    for (n = 0; n < 400 && rx_count !== 32'hc; n++) @(posedge aclk);
    chk(rx_count, 32'hc);
    wr(`SOMX_OFS_CTRL, 32'h3);
    cs = 3'h0;
    for (int i = 0; i < 6; i++) begin
      cs = (i < 3) ? cs | (3'h1 << i) : cs & ~(3'h1 << (i - 3));
      @(posedge aclk);
      compare_state <= cs;
      repeat (10) @(posedge aclk);
      @(negedge aclk);
      chk(rx_cmp, cs);
    end
    $display("t_pulse done");
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_scale();
    t_map();
    t_modes();
    t_err();
    t_pulse();
    finish_test();
  end
endmodule

/* File: src/somx_cfg.svh */
`ifndef SOMX_CFG_SVH
`define SOMX_CFG_SVH
// register byte offsets
`define SOMX_OFS_SEL0     12'h000
`define SOMX_OFS_SEL1     12'h004
`define SOMX_OFS_SEL2     12'h008
`define SOMX_OFS_CTRL     12'h00c
`define SOMX_OFS_STAT     12'h010
`define SOMX_OFS_IRQ_ST   12'h014
`define SOMX_OFS_IRQ_EN   12'h018
`define SOMX_OFS_IRQ_CLR  12'h01c
`define SOMX_OFS_COUNT    12'h020
`define SOMX_OFS_WAIT     12'h024
// reset values
`define SOMX_SEL0_RST     32'h0003_0303
`define SOMX_SEL1_RST     32'h0010_1010
`define SOMX_SEL2_RST     32'h0001_0101
`define SOMX_WAIT_RST     32'h0000_0400
// field positions
`define SOMX_POS_LSB      0
`define SOMX_VEL_LSB      8
`define SOMX_TRQ_LSB      16
`define SOMX_RSV_BIT      7
// function codes
`define SOMX_FN_DISABLED  7'h00
`define SOMX_FN_BRAKE     7'h03
`define SOMX_FN_CMP       7'h14
`define SOMX_PULSE_CMP    1'b1
// ctrl bits
`define SOMX_CTRL_INIT    0
`define SOMX_CTRL_PSEL    1
`define SOMX_CTRL_CMP3    2
// irq bits
`define SOMX_IRQ_ERR1     0
`define SOMX_IRQ_ERR2     1
`define SOMX_IRQ_READY    2
// pulse timing: 4 Mpulse/s after x4
`define SOMX_PULSE_MAX_HZ 4000000
`define SOMX_CLK_HZ       25000000
`define SOMX_EDGE_CYC ((`SOMX_CLK_HZ + `SOMX_PULSE_MAX_HZ - 1) / `SOMX_PULSE_MAX_HZ)
`endif

/* File: src/somx_output_mux.sv */
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`include "somx_cfg.svh"
// Operation
// - one function code may drive several pins identically
// - disabled pin stays off; network status unaffected
// - brake or compare set in only some modes raises error 1/2
// - output_pin_q pins off until initialization completes and during reset
// - internal mode override decides which field is used
// - frequency analysis forces position, velocity or torque mode
// - trial run, forced stop and retract force position mode
// - reserved top bit excluded from error checks
// - function number is the low seven bits
// - divided pulses out as a/b quadrature, edge rate limited
// - pulse select one turns a/b pairs into compare 1 and 2
// - compare 3 has its own pair
// - scale a/b/z decoded with x4 multiplication
// - adjustable scale power-up wait
// - selector word: pos, vel, torque bytes, zero top byte
module somx_output_mux
  import somx_pkg::*;
#(
  parameter int NOUT = 3,
  parameter int NFN  = 32,
  parameter int CW   = 32
) (
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [11:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [11:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic [1:0]      host_mode,
  input  wire logic [2:0]      fra_kind,
  input  wire logic            trial_run,
  input  wire logic            forced_stop_pos,
  input  wire logic            retracting,
  input  wire logic [NFN-1:0]  function_state,
  input  wire logic [CW-1:0]   divided_position,
  input  wire logic [2:0]      compare_state,
  input  wire logic            scale_phase_a_in,
  input  wire logic            scale_phase_b_in,
  input  wire logic            scale_phase_z_in,
  input  wire logic            scale_serial_line,
  output logic [NOUT-1:0]      output_pin_q,
  output logic                 phase_a_or_compare1_out,
  output logic                 phase_a_or_compare1_out_n,
  output logic                 phase_b_or_compare2_out,
  output logic                 phase_b_or_compare2_out_n,
  output logic                 compare3_out,
  output logic                 compare3_out_n,
  output logic                 output_function_error_1,
  output logic                 output_function_error_2,
  output logic                 scale_ready_q,
  output logic                 irq_q
);
  // ==========================================================
  // functions
  function automatic logic [6:0] fn_of(input logic [7:0] code);
    // reserved bit dropped before any use
    fn_of = code[6:0];
  endfunction
  // count of modes holding fn (0..3)
  function automatic logic [1:0] fn_hits(input logic [31:0] w,
                                         input logic [6:0]  fn);
    fn_hits = 2'((fn_of(w[`SOMX_POS_LSB+:8]) == fn) ? 1 : 0)
            + 2'((fn_of(w[`SOMX_VEL_LSB+:8]) == fn) ? 1 : 0)
            + 2'((fn_of(w[`SOMX_TRQ_LSB+:8]) == fn) ? 1 : 0);
  endfunction

  // ==========================================================
  // registers
  logic [31:0]     sel_q [NOUT];
  logic [2:0]      ctrl_q;
  logic [2:0]      irq_st_q, irq_en_q;
  logic [31:0]     wait_q, wait_cnt_q;
  logic            aw_have_q, w_have_q;
  logic [11:0]     awaddr_q;
  logic [31:0]     wdata_q;
  logic            init_done_q;
  logic            psel_q;
  logic            err1_q, err2_q;
  logic [CW-1:0]   scale_cnt;
  logic            scale_z;
  logic            pa, pb;

  // ==========================================================
  // effective mode
  // analysis forcing
  wire fra_pos = (fra_kind == SOMX_FRA_PLOOP) ||
                 (fra_kind == SOMX_FRA_TS_AUTO);
  wire fra_vel = (fra_kind == SOMX_FRA_VLOOP) ||
                 (fra_kind == SOMX_FRA_TS_VERT);
  wire fra_trq = (fra_kind == SOMX_FRA_TS_NORM);
  wire force_pos = trial_run || forced_stop_pos || retracting;
  somx_mode_e eff_mode;
  assign eff_mode = (force_pos || fra_pos) ? SOMX_MODE_POS :
                    fra_vel ? SOMX_MODE_VEL :
                    fra_trq ? SOMX_MODE_TRQ :
                    (host_mode == 2'(SOMX_MODE_VEL)) ? SOMX_MODE_VEL :
                    (host_mode == 2'(SOMX_MODE_TRQ)) ? SOMX_MODE_TRQ :
                    SOMX_MODE_POS;

  // ==========================================================
  // per-pin selection and error checks
  logic [NOUT-1:0] pin_d;
  logic            err1_d, err2_d;
  always_comb begin
    logic [7:0] code;
    logic [6:0] fn;
    logic [1:0] hb, hc;
    code   = 8'h00;
    fn     = 7'h00;
    hb     = 2'h0;
    hc     = 2'h0;
    err1_d = 1'b0;
    err2_d = 1'b0;
    pin_d  = '0;
    for (int i = 0; i < NOUT; i++) begin
      case (eff_mode)
        SOMX_MODE_VEL: code = sel_q[i][`SOMX_VEL_LSB+:8];
        SOMX_MODE_TRQ: code = sel_q[i][`SOMX_TRQ_LSB+:8];
        default:       code = sel_q[i][`SOMX_POS_LSB+:8];
      endcase
      fn = fn_of(code);
      pin_d[i] = (fn != `SOMX_FN_DISABLED) && (32'(fn) < NFN) &&
                 function_state[fn[4:0]];
      hb = fn_hits(sel_q[i], `SOMX_FN_BRAKE);
      hc = fn_hits(sel_q[i], `SOMX_FN_CMP);
      if (hb != 2'h0 && hb != 2'h3)
        err1_d = 1'b1;
      if (hc != 2'h0 && hc != 2'h3)
        err2_d = 1'b1;
    end
  end

  // ==========================================================
  // axi4-lite slave
  wire        wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
  wire        rd_go   = s_axi_arvalid && s_axi_arready;
  wire [11:0] wa      = awaddr_q;
  wire [1:0]  wsel    = 2'(wa[3:2]);
  wire        wr_sel  = wr_go && (wa < `SOMX_OFS_CTRL);
  wire        wr_ctrl = wr_go && (wa == `SOMX_OFS_CTRL);
  wire        wr_en   = wr_go && (wa == `SOMX_OFS_IRQ_EN);
  wire        wr_clr  = wr_go && (wa == `SOMX_OFS_IRQ_CLR);
  wire        wr_wait = wr_go && (wa == `SOMX_OFS_WAIT);
  wire        wr_ok   = wr_sel || wr_ctrl || wr_en || wr_clr || wr_wait;
  wire [31:0] stat_w  = {26'h0, scale_z, scale_ready_q, err2_q, err1_q,
                         psel_q, init_done_q};
  wire [11:0] ra      = s_axi_araddr;
  wire        ra_ok   = (ra <= `SOMX_OFS_WAIT) && (ra[1:0] == 2'h0);
  wire [31:0] rd_w    =
    (ra == `SOMX_OFS_SEL0)   ? sel_q[0] :
    (ra == `SOMX_OFS_SEL1)   ? sel_q[1] :
    (ra == `SOMX_OFS_SEL2)   ? sel_q[2] :
    (ra == `SOMX_OFS_CTRL)   ? {29'h0, ctrl_q} :
    (ra == `SOMX_OFS_STAT)   ? stat_w :
    (ra == `SOMX_OFS_IRQ_ST) ? {29'h0, irq_st_q} :
    (ra == `SOMX_OFS_IRQ_EN) ? {29'h0, irq_en_q} :
    (ra == `SOMX_OFS_COUNT)  ? 32'(scale_cnt) :
    (ra == `SOMX_OFS_WAIT)   ? wait_q : 32'h0;
  // byte-lane mask, unstrobed bytes written as zero
  wire [31:0] wmask   = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata & wmask;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_w;
        s_axi_rresp  <= ra_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_have_q && aresetn;
  assign s_axi_wready  = !w_have_q && aresetn;
  assign s_axi_arready = !s_axi_rvalid && aresetn;

  // ==========================================================
  // configuration, status and interrupts
  wire [2:0] ev = {scale_ready_q == 1'b0 && wait_cnt_q == 32'h1,
                   err2_d && !err2_q, err1_d && !err1_q};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q[0] <= `SOMX_SEL0_RST;
      sel_q[1] <= `SOMX_SEL1_RST;
      sel_q[2] <= `SOMX_SEL2_RST;
      ctrl_q   <= 3'h0;
      irq_en_q <= 3'h0;
      irq_st_q <= 3'h0;
      wait_q   <= `SOMX_WAIT_RST;
    end else begin
      if (wr_sel && 32'(wsel) < NOUT)
        sel_q[wsel] <= {8'h00, wdata_q[23:0]};
      if (wr_ctrl)
        ctrl_q <= wdata_q[2:0];
      if (wr_en)
        irq_en_q <= wdata_q[2:0];
      if (wr_wait)
        wait_q <= wdata_q;
      // set wins over clear
      irq_st_q <= (irq_st_q & ~(wr_clr ? wdata_q[2:0] : 3'h0)) | ev;
    end
  end
  assign init_done_q = ctrl_q[`SOMX_CTRL_INIT];
  assign psel_q      = ctrl_q[`SOMX_CTRL_PSEL];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_cnt_q    <= `SOMX_WAIT_RST;
      scale_ready_q <= 1'b0;
    end else if (wr_wait) begin
      // new wait value restarts the scale wait
      wait_cnt_q    <= wdata_q;
      scale_ready_q <= 1'b0;
    end else if (!scale_ready_q) begin
      if (wait_cnt_q <= 32'h1)
        scale_ready_q <= 1'b1;
      else
        wait_cnt_q <= wait_cnt_q - 32'h1;
    end
  end

  somx_scale_decoder #(.CW(CW)) u_dec (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .enable           (scale_ready_q),
    .scale_phase_a_in (scale_phase_a_in),
    .scale_phase_b_in (scale_phase_b_in),
    .scale_phase_z_in (scale_phase_z_in),
    .count_q          (scale_cnt),
    .zero_seen_q      (scale_z)
  );
  somx_pulse_gen #(.CW(CW)) u_pg (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .target    (divided_position),
    .phase_a_q (pa),
    .phase_b_q (pb)
  );

  // ==========================================================
  // output registers
  wire a_d = psel_q == `SOMX_PULSE_CMP ? compare_state[0] : pa;
  wire b_d = psel_q == `SOMX_PULSE_CMP ? compare_state[1] : pb;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_pin_q <= '0;
      err1_q       <= 1'b0;
      err2_q       <= 1'b0;
      irq_q        <= 1'b0;
      phase_a_or_compare1_out   <= 1'b0;
      phase_a_or_compare1_out_n <= 1'b1;
      phase_b_or_compare2_out   <= 1'b0;
      phase_b_or_compare2_out_n <= 1'b1;
      compare3_out   <= 1'b0;
      compare3_out_n <= 1'b1;
    end else begin
      output_pin_q <= init_done_q ? pin_d : '0;
      err1_q       <= err1_d;
      err2_q       <= err2_d;
      irq_q        <= |((irq_st_q | ev) & irq_en_q);
      phase_a_or_compare1_out   <= a_d;
      phase_a_or_compare1_out_n <= !a_d;
      phase_b_or_compare2_out   <= b_d;
      phase_b_or_compare2_out_n <= !b_d;
      compare3_out   <= compare_state[2];
      compare3_out_n <= !compare_state[2];
    end
  end
  assign output_function_error_1 = err1_q;
  assign output_function_error_2 = err2_q;
endmodule

/* File: src/somx_pkg.sv */
package somx_pkg;
  typedef enum logic [1:0] {
    SOMX_MODE_POS,
    SOMX_MODE_VEL,
    SOMX_MODE_TRQ
  } somx_mode_e;
  typedef enum logic [2:0] {
    SOMX_FRA_NONE,
    SOMX_FRA_PLOOP,
    SOMX_FRA_VLOOP,
    SOMX_FRA_TS_AUTO,
    SOMX_FRA_TS_VERT,
    SOMX_FRA_TS_NORM
  } somx_fra_e;
endpackage

/* File: src/somx_pulse_gen.sv */
`timescale 1ns/1ns
`include "somx_cfg.svh"
module somx_pulse_gen
  import somx_pkg::*;
#(
  parameter int CW = 32
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [CW-1:0] target,
  output logic               phase_a_q,
  output logic               phase_b_q
);
  localparam int GAP = `SOMX_EDGE_CYC;
  logic [CW-1:0] pos_q;
  logic [7:0]    gap_q;
  wire  fwd  = $signed(target - pos_q) > 0;
  wire  move = (target != pos_q) && (gap_q == 8'h00);
  wire  [1:0] ph  = pos_q[1:0] + (fwd ? 2'h1 : 2'h3);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_q     <= '0;
      gap_q     <= 8'h00;
      phase_a_q <= 1'b0;
      phase_b_q <= 1'b0;
    end else if (move) begin
      pos_q     <= fwd ? pos_q + CW'(1) : pos_q - CW'(1);
      gap_q     <= 8'(GAP - 1);
      phase_a_q <= ph[1];
      phase_b_q <= ph[1] ^ ph[0];
    end else if (gap_q != 8'h00) begin
      gap_q <= gap_q - 8'h01;
    end
  end
endmodule

/* File: src/somx_scale_decoder.sv */
`timescale 1ns/1ns
`include "somx_cfg.svh"
module somx_scale_decoder
  import somx_pkg::*;
#(
  parameter int CW = 32
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          enable,
  input  wire logic          scale_phase_a_in,
  input  wire logic          scale_phase_b_in,
  input  wire logic          scale_phase_z_in,
  output logic [CW-1:0]      count_q,
  output logic               zero_seen_q
);
  logic [1:0] ab_q;
  logic       z_q;
  wire  [1:0] ab_now = {scale_phase_a_in, scale_phase_b_in};
  // x4 decode: every edge of a or b counts while enable is high
  wire        step   = enable && (ab_now != ab_q);
  wire        up     = (ab_q[1] ^ ab_now[0]);
  wire        z_rise = enable && scale_phase_z_in && !z_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ab_q        <= 2'h0;
      z_q         <= 1'b0;
      count_q     <= '0;
      zero_seen_q <= 1'b0;
    end else begin
      ab_q        <= ab_now;
      z_q         <= scale_phase_z_in;
      zero_seen_q <= z_rise;
      if (step && up)
        count_q <= count_q + CW'(1);
      else if (step)
        count_q <= count_q - CW'(1);
    end
  end
endmodule
